/* File: dpss_master.sv */
// Behavioural two-wire bus master that drives the serial link
`timescale 1ns/10ps
module dpss_master (
  input  wire logic i_mclk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  int slow = 0;  // Extra low-phase cycles, stretches the clock

  // Idle bus: clock stands high between frames, data released
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // Wait n cycles, then move just after the edge
  task wt(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : wt

  task bit_slot(input logic b, output logic r);
    o_sda_low = ~b;
    wt(3 + slow);
    o_scl = 1'b1;
    wt(3);
    r = i_sda;
    wt(3);
    o_scl = 1'b0;
    wt(3);
  endtask : bit_slot

  // Start or repeated start: data falls while clock high
  task start;
    o_sda_low = 1'b0;
    wt(3);
    o_scl = 1'b1;
    wt(3);
    o_sda_low = 1'b1;
    wt(3);
    o_scl = 1'b0;
    wt(3);
  endtask : start

  // Stop: data rises while clock high
  task stop;
    o_sda_low = 1'b1;
    wt(3);
    o_scl = 1'b1;
    wt(3);
    o_sda_low = 1'b0;
    wt(6);
  endtask : stop

  // Eight bits out, then sample the slave's acknowledge
  task send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(b[i], r);
    end
    bit_slot(1'b1, r);
    ack = ~r;
  endtask : send_byte

  // Eight bits in, then acknowledge or refuse
  task recv_byte(input logic ack_m, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, b[i]);
    end
    bit_slot(~ack_m, r);
  endtask : recv_byte
endmodule : dpss_master

/* File: dpss_pkg.sv */
// Shared constants and types for the digital potentiometer serial slave
package dpss_pkg;
  localparam int           POS_W        = 10;
  localparam int           TAPS         = 1024;
  localparam int           NUM_SAVED    = 4;
  localparam int           SEL_W        = 2;
  localparam logic [3:0]   DEV_ID       = 4'hA;  // Arbitrary device type value
  localparam int           ID_MSB       = 7;
  localparam int           ID_LSB       = 4;
  localparam int           ADDR_HI_BIT  = 2;
  localparam int           ADDR_LO_BIT  = 1;
  localparam int           RW_BIT       = 0;
  localparam int           OP_MSB       = 7;
  localparam int           OP_LSB       = 5;
  localparam int           SEL_MSB      = 3;
  localparam int           SEL_LSB      = 2;
  localparam logic [2:0]   OP_ST_WIPER  = 3'h2;  // Wiper to saved register
  localparam logic [2:0]   OP_LD_WIPER  = 3'h3;  // Saved register to wiper
  localparam logic [2:0]   OP_RD_WIPER  = 3'h4;
  localparam logic [2:0]   OP_WR_WIPER  = 3'h5;
  localparam logic [2:0]   OP_RD_SAVED  = 3'h6;
  localparam logic [2:0]   OP_WR_SAVED  = 3'h7;
  localparam logic [1:0]   IDX_ADDR     = 2'h0;
  localparam logic [1:0]   IDX_INSTR    = 2'h1;
  localparam logic [1:0]   IDX_DLO      = 2'h2;
  localparam logic [1:0]   IDX_DHI      = 2'h3;
  localparam logic [3:0]   BYTE_BITS    = 4'h8;
  localparam logic [9:0]   SAVED_RST    = 10'h200;
  localparam logic [9:0]   WIPER_RST    = 10'h000;
  localparam int           NV_WRITE_MS  = 5;
  localparam int           CLK_KHZ      = 250000;
  localparam int           NV_WRITE_CYC = NV_WRITE_MS * CLK_KHZ;
  localparam int           BUSY_W       = 21;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} dpss_state_t;

  typedef struct packed {
    logic [2:0] op;
    logic [1:0] sel;
  } dpss_instr_t;
endpackage : dpss_pkg

/* File: dpss_slave.sv */
// Two-wire slave and register logic of a single digital potentiometer
`timescale 1ns/10ps
module dpss_slave
  import dpss_pkg::*;
#(
  parameter int NV_WRITE_CYCLES = NV_WRITE_CYC
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rstn,
  input  wire logic              i_scl,
  input  wire logic              i_sda_i,
  output logic                   o_sda_o,
  output logic                   o_sda_oe,
  input  wire logic              i_addr_strap_hi,
  input  wire logic              i_addr_strap_lo,
  input  wire logic              i_wp_n,
  output logic [POS_W-1:0]       o_wiper_pos,
  output logic [TAPS-1:0]        o_tap_sel,
  output logic                   o_busy
);

  localparam logic [TAPS-1:0]   TAP_ONE  = {{(TAPS-1){1'b0}}, 1'b1};
  localparam logic [BUSY_W-1:0] BUSY_TOP = BUSY_W'(NV_WRITE_CYCLES - 1);

  logic [4:0]                   sync1_r;
  logic [4:0]                   sync2_r;
  logic                         scl_d_r;
  logic                         sda_d_r;
  logic                         scl_s;
  logic                         sda_s;
  logic                         strap_hi_s;
  logic                         strap_lo_s;
  logic                         wp_n_s;
  logic                         scl_rise;
  logic                         scl_fall;
  logic                         start_ev;
  logic                         stop_ev;
  dpss_state_t                  st_r;
  dpss_state_t                  st_after_r;
  logic [3:0]                   cnt_r;
  logic [1:0]                   idx_r;
  logic [7:0]                   sh_r;
  logic [7:0]                   tx_r;
  logic                         tx_hi_r;
  logic                         mack_r;
  logic                         rw_r;
  logic [7:0]                   lo_r;
  logic                         oe_r;
  dpss_instr_t                  instr_r;
  dpss_instr_t                  instr_in;
  logic [NUM_SAVED-1:0][POS_W-1:0] saved_r;
  logic [POS_W-1:0]             wiper_r;
  logic [TAPS-1:0]              tap_r;
  logic                         init_r;
  logic                         nv_pend_r;
  logic [POS_W-1:0]             nv_data_r;
  logic                         busy_r;
  logic [BUSY_W-1:0]            busy_cnt_r;
  logic                         byte_done;
  logic                         addr_match;
  logic                         instr_ok;
  logic                         is_read;
  logic                         wr_wiper_ev;
  logic                         ld_wiper_ev;
  logic [POS_W-1:0]             rd_val;
  logic [7:0]                   first_tx;

  // Pins cross into the clock domain through two flops; the link clock is synchronised along with them
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_r <= 5'h1F;
      sync2_r <= 5'h1F;
    end else begin
      sync1_r <= {i_wp_n, i_addr_strap_lo, i_addr_strap_hi, i_sda_i, i_scl};
      sync2_r <= sync1_r;
    end
  end

  assign scl_s      = sync2_r[0];
  assign sda_s      = sync2_r[1];
  assign strap_hi_s = sync2_r[2];
  assign strap_lo_s = sync2_r[3];
  assign wp_n_s     = sync2_r[4];

  // Edge history taken from the settled stage only
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_ev  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // Byte decode
  assign byte_done    = scl_fall & (st_r == ST_RX) & (cnt_r == BYTE_BITS);
  // One driver for the whole decoded instruction
  assign instr_in     = '{op: sh_r[OP_MSB:OP_LSB], sel: sh_r[SEL_MSB:SEL_LSB]};
  assign addr_match   = (sh_r[ID_MSB:ID_LSB] == DEV_ID) && (sh_r[ADDR_HI_BIT] == strap_hi_s) &&
                        (sh_r[ADDR_LO_BIT] == strap_lo_s) && !busy_r;
  assign is_read      = (instr_in.op == OP_RD_WIPER) || (instr_in.op == OP_RD_SAVED);
  assign instr_ok     = is_read ? rw_r :
                        (!rw_r && (instr_in.op >= OP_ST_WIPER));
  assign wr_wiper_ev  = byte_done && (idx_r == IDX_DHI) && (instr_r.op == OP_WR_WIPER);
  assign ld_wiper_ev  = byte_done && (idx_r == IDX_INSTR) && instr_ok &&
                        (instr_in.op == OP_LD_WIPER);
  assign rd_val       = (instr_r.op == OP_RD_WIPER) ? wiper_r : saved_r[instr_r.sel];
  assign first_tx     = rd_val[7:0];

  // Link protocol: receive, acknowledge, transmit
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r       <= ST_IDLE;
      st_after_r <= ST_IDLE;
      cnt_r      <= 4'h0;
      idx_r      <= IDX_ADDR;
      sh_r       <= 8'h00;
      tx_r       <= 8'h00;
      tx_hi_r    <= 1'b0;
      mack_r     <= 1'b0;
      rw_r       <= 1'b0;
      lo_r       <= 8'h00;
      oe_r       <= 1'b0;
      instr_r    <= '0;
    end else if (start_ev) begin
      st_r  <= ST_RX;
      cnt_r <= 4'h0;
      idx_r <= IDX_ADDR;
      oe_r  <= 1'b0;
    end else if (stop_ev) begin
      st_r <= ST_IDLE;
      oe_r <= 1'b0;
    end else begin
      case (st_r)
        ST_RX: begin
          if (scl_rise) begin
            sh_r  <= {sh_r[6:0], sda_s};
            cnt_r <= cnt_r + 4'h1;
          end else if (byte_done) begin
            st_r <= ST_ACK;
            oe_r <= 1'b1;
            case (idx_r)
              IDX_ADDR: begin
                if (!addr_match) begin
                  st_r <= ST_IDLE;
                  oe_r <= 1'b0;
                end
                rw_r       <= sh_r[RW_BIT];
                st_after_r <= ST_RX;
              end
              IDX_INSTR: begin
                instr_r <= instr_in;
                if (!instr_ok) begin
                  st_r <= ST_IDLE;
                  oe_r <= 1'b0;
                end
                if (is_read) begin
                  st_after_r <= ST_TX;
                end else if (instr_in.op == OP_WR_WIPER || instr_in.op == OP_WR_SAVED) begin
                  st_after_r <= ST_RX;
                end else begin
                  st_after_r <= ST_IDLE;
                end
              end
              IDX_DLO: begin
                lo_r       <= sh_r;
                st_after_r <= ST_RX;
              end
              default: begin
                st_after_r <= ST_IDLE;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            st_r    <= st_after_r;
            cnt_r   <= 4'h0;
            idx_r   <= idx_r + 2'h1;
            oe_r    <= 1'b0;
            tx_hi_r <= 1'b0;
            if (st_after_r == ST_TX) begin
              tx_r <= first_tx;
              oe_r <= ~first_tx[7];
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (cnt_r == BYTE_BITS) begin
              oe_r <= 1'b0;
              st_r <= ST_MACK;
            end else begin
              tx_r <= {tx_r[6:0], 1'b0};
              oe_r <= ~tx_r[6];
            end
          end
        end
        ST_MACK: begin
          // Master ack keeps reading, low and high bytes alternate
          if (scl_rise) begin
            mack_r <= ~sda_s;
          end else if (scl_fall) begin
            st_r    <= mack_r ? ST_TX : ST_IDLE;
            cnt_r   <= 4'h0;
            tx_hi_r <= ~tx_hi_r;
            tx_r    <= tx_hi_r ? first_tx : {6'h00, rd_val[9:8]};
            oe_r    <= mack_r & (tx_hi_r ? ~first_tx[7] : 1'b1);
          end
        end
        default: begin
          st_r <= ST_IDLE;
          oe_r <= 1'b0;
        end
      endcase
    end
  end

  assign o_sda_o  = 1'b0;
  assign o_sda_oe = oe_r;

  // Wiper register; recall happens one cycle after reset release
  // ten-bit wiper
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      init_r  <= 1'b1;
      wiper_r <= WIPER_RST;
    end else if (init_r) begin
      init_r  <= 1'b0;
      wiper_r <= saved_r[0];
    end else if (wr_wiper_ev) begin
      wiper_r <= {sh_r[1:0], lo_r};
    end else if (ld_wiper_ev) begin
      wiper_r <= saved_r[instr_in.sel];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      tap_r <= TAP_ONE;
    end else begin
      tap_r <= TAP_ONE << wiper_r;
    end
  end

  assign o_wiper_pos = wiper_r;
  assign o_tap_sel   = tap_r;

  // Saved-register update waits for stop; flops stand in for the nonvolatile cells
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      nv_pend_r <= 1'b0;
      nv_data_r <= 10'h000;
      saved_r   <= {NUM_SAVED{SAVED_RST}};
    end else if (start_ev) begin
      nv_pend_r <= 1'b0;
    end else if (stop_ev) begin
      nv_pend_r <= 1'b0;
      if (nv_pend_r && wp_n_s) begin
        saved_r[instr_r.sel] <= nv_data_r;
      end
    end else if (byte_done && (idx_r == IDX_DHI) && (instr_r.op == OP_WR_SAVED)) begin
      nv_pend_r <= 1'b1;
      nv_data_r <= {sh_r[1:0], lo_r};
    end else if (byte_done && (idx_r == IDX_INSTR) && instr_ok &&
                 (instr_in.op == OP_ST_WIPER)) begin
      nv_pend_r <= 1'b1;
      nv_data_r <= wiper_r;
    end
  end

  // Internal write cycle; a blocked write starts no busy time so the link stays ready
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_r     <= 1'b0;
      busy_cnt_r <= '0;
    end else if (stop_ev && nv_pend_r && wp_n_s) begin
      busy_r     <= 1'b1;
      busy_cnt_r <= '0;
    end else if (busy_r) begin
      busy_cnt_r <= busy_cnt_r + BUSY_W'(1);
      if (busy_cnt_r == BUSY_TOP) begin
        busy_r <= 1'b0;
      end
    end
  end

  assign o_busy = busy_r;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  sequence s_addr_byte;
    byte_done && (idx_r == IDX_ADDR);
  endsequence

  sequence s_blocked_stop;
    stop_ev && nv_pend_r && !wp_n_s;
  endsequence

  property p_capture;
    (st_r == ST_RX) && scl_rise && !start_ev && !stop_ev |=> sh_r[0] == $past(sda_s);
  endproperty
  a_capture: assert property (p_capture) else $error("bit not captured on rise");

  property p_drive_fall;
    $rose(o_sda_oe) |-> $past(scl_fall);
  endproperty
  a_drive_fall: assert property (p_drive_fall) else $error("data pulled outside clock fall");

  property p_drain;
    o_sda_o == 1'b0;
  endproperty
  a_drain: assert property (p_drain) else $error("data pin driven high");

  property p_match_ack;
    s_addr_byte and (addr_match && !start_ev && !stop_ev) |=> o_sda_oe && (st_r == ST_ACK);
  endproperty
  a_match_ack: assert property (p_match_ack) else $error("matching address not acked");

  property p_nomatch;
    s_addr_byte and (!addr_match && !start_ev && !stop_ev) |=> !o_sda_oe && (st_r == ST_IDLE);
  endproperty
  a_nomatch: assert property (p_nomatch) else $error("foreign address acked");

  property p_protect;
    !wp_n_s |=> $stable(saved_r);
  endproperty
  a_protect: assert property (p_protect) else $error("saved register changed under protect");

  property p_recall;
    $fell(init_r) |-> (wiper_r == saved_r[0]);
  endproperty
  a_recall: assert property (p_recall) else $error("wiper not recalled at power-up");

  property p_tap;
    ##1 (o_tap_sel == (TAP_ONE << $past(wiper_r))) && $onehot(o_tap_sel);
  endproperty
  a_tap: assert property (p_tap) else $error("tap selection does not follow wiper");

  property p_busy_nak;
    s_addr_byte and busy_r |=> !o_sda_oe [*2];
  endproperty
  a_busy_nak: assert property (p_busy_nak) else $error("address acked while busy");

  property p_keep;
    !init_r && !wr_wiper_ev && !ld_wiper_ev |=> $stable(wiper_r);
  endproperty
  a_keep: assert property (p_keep) else $error("wiper changed without cause");

  property p_blocked;
    s_blocked_stop |=> !busy_r && (st_r == ST_IDLE) && $stable(saved_r);
  endproperty
  a_blocked: assert property (p_blocked) else $error("blocked write not ignored");

endmodule : dpss_slave

/* File: test_digital_pot_serial_slave.sv */
// Self-checking bench for the potentiometer two-wire slave
`timescale 1ns/10ps
module test_digital_pot_serial_slave;
  import dpss_pkg::*;
  localparam int NVW = 200;  // Short saved-write time keeps the run brief
  logic             i_mclk;
  logic             i_rstn;
  logic             strap_hi;
  logic             strap_lo;
  logic             wp_n;
  logic             scl;
  logic             m_low;
  logic             sda_o;
  logic             sda_oe;
  logic             sda;
  logic [POS_W-1:0] wiper;
  logic [TAPS-1:0]  tap;
  logic             busy;
  logic             ak;
  int               k;
  int               n_mismatch = 0;
  int               n_compared = 0;
  logic [9:0]       tbl [4] = '{10'h3FF, 10'h001, 10'h2AA, 10'h155};

  // Pulled-up wire: whoever pulls low wins
  assign sda = (sda_oe ? sda_o : 1'b1) & ~m_low;

  dpss_slave #(.NV_WRITE_CYCLES(NVW)) uut (
    .i_mclk          (i_mclk),
    .i_rstn          (i_rstn),
    .i_scl           (scl),
    .i_sda_i         (sda),
    .o_sda_o         (sda_o),
    .o_sda_oe        (sda_oe),
    .i_addr_strap_hi (strap_hi),
    .i_addr_strap_lo (strap_lo),
    .i_wp_n          (wp_n),
    .o_wiper_pos     (wiper),
    .o_tap_sel       (tap),
    .o_busy          (busy)
  );

  dpss_master mst (
    .i_mclk    (i_mclk),
    .i_sda     (sda),
    .o_scl     (scl),
    .o_sda_low (m_low)
  );

  // Free-running system clock
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  // Verdict and end of run
  task stop_test;
    if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  // Compare and count
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task ack_is(input logic e);
    chk({15'h0, ak}, {15'h0, e});
  endtask : ack_is

  function automatic logic [7:0] ab(input logic rd);
    return {DEV_ID, 1'b0, strap_hi, strap_lo, rd};
  endfunction : ab

  function automatic logic [7:0] ins(input logic [2:0] op, input logic [1:0] sel);
    return {op, 1'b0, sel, 2'b00};
  endfunction : ins

  // Wiper value and its one-hot tap decode
  task wiper_is(input logic [9:0] v);
    chk({6'h0, wiper}, {6'h0, v});
    chk({15'h0, tap === (TAPS'(1) << v)}, 16'h1);
  endtask : wiper_is

  task head(input logic rd, input logic [7:0] b);
    mst.start;
    mst.send_byte(ab(rd), ak);
    ack_is(1'b1);
    mst.send_byte(b, ak);
    ack_is(1'b1);
  endtask : head

  task wr10(input logic [7:0] b, input logic [9:0] v);
    head(1'b0, b);
    mst.send_byte(v[7:0], ak);
    ack_is(1'b1);
    mst.send_byte({6'h0, v[9:8]}, ak);
    ack_is(1'b1);
    mst.stop;
  endtask : wr10

  // Two-byte read, low byte first, master refuses the second
  task rd_is(input logic [7:0] b, input logic [9:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    head(1'b1, b);
    mst.recv_byte(1'b1, lo);
    mst.recv_byte(1'b0, hi);
    mst.stop;
    chk({8'h0, lo}, {8'h0, v[7:0]});
    chk({8'h0, hi}, {14'h0, v[9:8]});
  endtask : rd_is

  task cmd(input logic [7:0] b);
    head(1'b0, b);
    mst.stop;
  endtask : cmd

  task probe(input logic [7:0] b);
    mst.start;
    mst.send_byte(b, ak);
    mst.stop;
  endtask : probe

  // Refused instruction: address acked, instruction not, link idles
  task bad_ins(input logic rd, input logic [7:0] b);
    mst.start;
    mst.send_byte(ab(rd), ak);
    ack_is(1'b1);
    mst.send_byte(b, ak);
    ack_is(1'b0);
    mst.stop;
  endtask : bad_ins

  // Bounded wait for the saved-write cycle to end
  task wait_idle;
    k = 0;
    while (busy === 1'b1 && k < NVW + 100) begin
      @(posedge i_mclk);
      #1;
      k++;
    end
    chk({15'h0, busy}, 16'h0);
    if (k >= NVW + 100) stop_test;
  endtask : wait_idle

  // Reset stands for power-up; saved registers come back at default
  task do_reset;
    i_rstn = 1'b0;
    mst.wt(20);
    chk({15'h0, sda_oe}, 16'h0);
    chk({15'h0, sda_o}, 16'h0);
    chk({15'h0, busy}, 16'h0);
    chk({6'h0, wiper}, {6'h0, WIPER_RST});
    i_rstn = 1'b1;
    mst.wt(4);
    wiper_is(SAVED_RST);
  endtask : do_reset

  // Wiper writes at full scale, one step above zero and two alternating bit patterns, read back, reads leave it alone
  task t_wiper;
    for (int i = 0; i < 4; i++) begin
      mst.slow = (i == 3) ? 5 : 0;
      wr10(ins(OP_WR_WIPER, 2'h0), tbl[i]);
      wiper_is(tbl[i]);
      rd_is(ins(OP_RD_WIPER, 2'h0), tbl[i]);
      wiper_is(tbl[i]);
    end
    mst.slow = 0;
  endtask : t_wiper

  // Every strap setting, matching and mismatching addresses
  task t_addr;
    for (int s = 0; s < 4; s++) begin
      {strap_hi, strap_lo} = s[1:0];
      mst.wt(4);
      probe(ab(1'b0));
      ack_is(1'b1);
      probe(ab(1'b0) ^ 8'h02);
      ack_is(1'b0);
      probe(ab(1'b0) ^ 8'h04);
      ack_is(1'b0);
      probe(ab(1'b0) ^ 8'h80);
      ack_is(1'b0);
    end
    // Opcode below the valid range, then direction bit against the opcode
    bad_ins(1'b0, ins(3'h1, 2'h0));
    bad_ins(1'b0, ins(OP_RD_WIPER, 2'h0));
    bad_ins(1'b1, ins(OP_WR_WIPER, 2'h0));
  endtask : t_addr

  // All four saved registers, each with its busy window
  task t_saved;
    for (int s = 0; s < 4; s++) begin
      wr10(ins(OP_WR_SAVED, s[1:0]), tbl[s]);
      chk({15'h0, busy}, 16'h1);
      wait_idle;
      chk({15'h0, k > NVW - 16 && k <= NVW + 4}, 16'h1);
    end
    for (int s = 0; s < 4; s++) begin
      rd_is(ins(OP_RD_SAVED, s[1:0]), tbl[s]);
    end
    wiper_is(tbl[3]);
  endtask : t_saved

  // Protected writes change nothing and leave the link usable
  task t_protect;
    wp_n = 1'b0;
    wr10(ins(OP_WR_SAVED, 2'h2), 10'h0AB);
    chk({15'h0, busy}, 16'h0);
    cmd(ins(OP_ST_WIPER, 2'h1));
    chk({15'h0, busy}, 16'h0);
    wp_n = 1'b1;
    rd_is(ins(OP_RD_SAVED, 2'h2), tbl[2]);
    rd_is(ins(OP_RD_SAVED, 2'h1), tbl[1]);
  endtask : t_protect

  // Load and store between wiper and saved registers
  task t_transfer;
    cmd(ins(OP_LD_WIPER, 2'h2));
    wiper_is(tbl[2]);
    wr10(ins(OP_WR_WIPER, 2'h0), 10'h0C3);
    cmd(ins(OP_ST_WIPER, 2'h0));
    chk({15'h0, busy}, 16'h1);
    probe(ab(1'b0));
    ack_is(1'b0);
    wait_idle;
    rd_is(ins(OP_RD_SAVED, 2'h0), 10'h0C3);
    wiper_is(10'h0C3);
  endtask : t_transfer

  // Main sequence, with a second reset at the end of the run
  initial begin
    i_rstn = 1'b0;
    strap_hi = 1'b1;
    strap_lo = 1'b0;
    wp_n = 1'b1;
    do_reset;
    t_wiper;
    t_addr;
    t_saved;
    t_protect;
    t_transfer;
    do_reset;
    stop_test;
  end
endmodule : test_digital_pot_serial_slave
